// file: logic/clock_ctrl_pkg.sv
package clock_ctrl_pkg;

    // Register offsets on the special-function register page
    localparam logic [7:0] ADDR_INT_CTRL = 8'h8A;
    localparam logic [7:0] ADDR_INT_CAL = 8'h8B;
    localparam logic [7:0] ADDR_EXT_CTRL = 8'h8C;
    localparam logic [7:0] ADDR_CLK_SEL = 8'h97;

    // Field positions
    localparam int INT_ON_BIT = 7;
    localparam int INT_OK_BIT = 6;
    localparam int INT_PRESC_LSB = 0;
    localparam int EXT_FLAG_BIT = 7;
    localparam int EXT_MODE_LSB = 4;
    localparam int EXT_RSVD_BIT = 3;
    localparam int EXT_RANGE_LSB = 0;
    localparam int PICK_BIT = 0;

    // Reset values
    localparam logic [7:0] INT_CTRL_RESET = 8'hC0;
    localparam logic [7:0] EXT_CTRL_RESET = 8'h00;
    localparam logic [7:0] CLK_SEL_RESET = 8'h00;
    // Stand-in for the factory trim; the value is arbitrary
    localparam logic [7:0] CAL_RESET_DEFAULT = 8'h80;

    // External mode codes
    localparam logic [2:0] MODE_CMOS = 3'h2;
    localparam logic [2:0] MODE_CMOS_HALF = 3'h3;
    localparam logic [2:0] MODE_XTAL = 3'h6;
    localparam logic [2:0] MODE_XTAL_HALF = 3'h7;

    // Settling counts, in filtered oscillator rising edges
    localparam int INT_SETTLE_EDGES = 16;
    localparam int XTAL_SETTLE_EDGES = 1024;

    // Internal prescaler codes: 00 /8, 01 /4, 10 /2, 11 /1
    typedef enum logic [1:0] {PRESC_DIV8, PRESC_DIV4, PRESC_DIV2, PRESC_DIV1} prescale_type;

    typedef enum logic {SRC_INT, SRC_EXT} source_type;

    typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_ARM} switch_state_type;

endpackage : clock_ctrl_pkg

// file: logic/osc_input_filter.sv
module osc_input_filter
(
    input wire logic clock,
    input wire logic rst,
    input wire logic rawIn,
    output logic level,
    output logic rise
);
    logic s1_q, s2_q, s3_q;
    logic level_q, level_d;
    logic rise_q, rise_d;

    // Level moves only once the second and third stages agree
    always_comb
    begin
        level_d = (s2_q == s3_q) ? s3_q : level_q;
        rise_d = level_d && !level_q;
    end

    // Three-stage chain plus filtered level
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
            rise_q <= 1'b0;
        end
        else
        begin
            s1_q <= rawIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
            rise_q <= rise_d;
        end
    end

    assign level = level_q;
    assign rise = rise_q;

endmodule : osc_input_filter

// file: logic/system_clock_source_control.sv
// Summary of operation
// [RULE_01] Reset leaves system clock on internal oscillator
// [RULE_02] Prescale codes 00..11 divide by 8,4,2,1
// [RULE_03] Control bit 7 switches internal oscillator
// [RULE_04] Bit 6 high only at programmed frequency
// [RULE_05] Calibration byte sets period, trimmed reset value
// [RULE_06] Software keeps calibration below frequency maximum
// [RULE_07] One write may enable and select internal
// [RULE_08] Select bit 0 picks source, rest reserved
// [RULE_09] External clock always offered to timers
// [RULE_10] Software switches only to settled sources
// [RULE_11] Crystal-valid flag set after settling, crystal only
// [RULE_12] Software waits before sampling crystal flag
// [RULE_13] Three-bit external mode decode
// [RULE_14] Three-bit drive range field in bits 2..0
// [RULE_15] External control bit 3 reads zero
// [RULE_16] Source change without shortened clock pulses
module system_clock_source_control
#(
    parameter logic [7:0] CalReset = clock_ctrl_pkg::CAL_RESET_DEFAULT,
    parameter int IntSettleEdges = clock_ctrl_pkg::INT_SETTLE_EDGES,
    parameter int XtalSettleEdges = clock_ctrl_pkg::XTAL_SETTLE_EDGES
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    input wire logic intOscRaw,
    input wire logic oscPinA,
    output logic intOscEnable,
    output logic [7:0] calTrim,
    output logic [2:0] extModeOut,
    output logic [2:0] extDriveOut,
    output logic extTimerClk,
    output logic sysClk
);
    import clock_ctrl_pkg::*;

    localparam int IntW = $clog2(IntSettleEdges + 1);
    localparam int XtalW = $clog2(XtalSettleEdges + 1);
    localparam logic [IntW-1:0] IntLimit = IntW'(IntSettleEdges);
    localparam logic [XtalW-1:0] XtalLimit = XtalW'(XtalSettleEdges);

    logic intLevel, intRise, extLevel, extRise;
    logic internalOscOn_q, internalOscOn_d;
    logic internalFreqOk_q, internalFreqOk_d;
    prescale_type internalPrescaleSel_q, internalPrescaleSel_d;
    logic [7:0] calibration_q, calibration_d;
    logic [2:0] externalModeSel_q, externalModeSel_d;
    logic [2:0] externalDriveRange_q, externalDriveRange_d;
    logic clockSourcePick_q, clockSourcePick_d;
    logic crystalSettledFlag_q, crystalSettledFlag_d;
    logic [IntW-1:0] intSettle_q, intSettle_d;
    logic [XtalW-1:0] xtalSettle_q, xtalSettle_d;
    logic [2:0] divCnt_q, divCnt_d;
    logic extHalf_q, extHalf_d;
    logic [7:0] rdata_q, rdata_d;
    logic intSrcLevel, extSrcLevel, crystalMode;
    logic wrIntCtrl, wrCal, wrExtCtrl, wrSel;

    // Oscillator inputs cross into the clock domain here
    osc_input_filter u_int_filter
    (
        .clock(clock),
        .rst(rst),
        .rawIn(intOscRaw),
        .level(intLevel),
        .rise(intRise)
    );

    osc_input_filter u_ext_filter
    (
        .clock(clock),
        .rst(rst),
        .rawIn(oscPinA),
        .level(extLevel),
        .rise(extRise)
    );

    // Write strobes per register
    assign wrIntCtrl = sfrWrite && (sfrAddr == ADDR_INT_CTRL);
    assign wrCal = sfrWrite && (sfrAddr == ADDR_INT_CAL);
    assign wrExtCtrl = sfrWrite && (sfrAddr == ADDR_EXT_CTRL);
    assign wrSel = sfrWrite && (sfrAddr == ADDR_CLK_SEL);
    assign crystalMode = (externalModeSel_q[2:1] == MODE_XTAL[2:1]);

    // Software-visible register next state
    always_comb
    begin
        internalOscOn_d = internalOscOn_q;
        internalPrescaleSel_d = internalPrescaleSel_q;
        calibration_d = calibration_q;
        externalModeSel_d = externalModeSel_q;
        externalDriveRange_d = externalDriveRange_q;
        clockSourcePick_d = clockSourcePick_q;
        if (wrIntCtrl)
        begin
            internalOscOn_d = sfrWdata[INT_ON_BIT]; // RULE_03
            internalPrescaleSel_d = prescale_type'(sfrWdata[INT_PRESC_LSB +: 2]);
        end
        if (wrCal)
        begin
            calibration_d = sfrWdata; // RULE_05
        end
        if (wrExtCtrl)
        begin
            externalModeSel_d = sfrWdata[EXT_MODE_LSB +: 3]; // RULE_13
            externalDriveRange_d = sfrWdata[EXT_RANGE_LSB +: 3]; // RULE_14
        end
        if (wrSel)
        begin
            clockSourcePick_d = sfrWdata[PICK_BIT]; // RULE_08
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            internalOscOn_q <= INT_CTRL_RESET[INT_ON_BIT]; // RULE_01
            internalPrescaleSel_q <= prescale_type'(INT_CTRL_RESET[INT_PRESC_LSB +: 2]);
            calibration_q <= CalReset; // RULE_05
            externalModeSel_q <= EXT_CTRL_RESET[EXT_MODE_LSB +: 3];
            externalDriveRange_q <= EXT_CTRL_RESET[EXT_RANGE_LSB +: 3];
            clockSourcePick_q <= CLK_SEL_RESET[PICK_BIT]; // RULE_01
        end
        else
        begin
            internalOscOn_q <= internalOscOn_d;
            internalPrescaleSel_q <= internalPrescaleSel_d;
            calibration_q <= calibration_d;
            externalModeSel_q <= externalModeSel_d;
            externalDriveRange_q <= externalDriveRange_d;
            clockSourcePick_q <= clockSourcePick_d;
        end
    end

    // Settling trackers for both oscillators
    always_comb
    begin
        intSettle_d = intSettle_q;
        internalFreqOk_d = internalFreqOk_q;
        if (!internalOscOn_d)
        begin
            intSettle_d = '0;
            internalFreqOk_d = 1'b0; // RULE_04
        end
        else if (intRise && !internalFreqOk_q)
        begin
            intSettle_d = intSettle_q + 1'b1;
            internalFreqOk_d = (intSettle_d == IntLimit); // RULE_04
        end
        xtalSettle_d = xtalSettle_q;
        crystalSettledFlag_d = crystalSettledFlag_q;
        if (wrExtCtrl || !crystalMode)
        begin
            // Any external-control write, or a non-crystal mode, restarts the settling count
            xtalSettle_d = '0;
            crystalSettledFlag_d = 1'b0; // RULE_11
        end
        else if (extRise && !crystalSettledFlag_q)
        begin
            xtalSettle_d = xtalSettle_q + 1'b1;
            crystalSettledFlag_d = (xtalSettle_d == XtalLimit); // RULE_11
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            intSettle_q <= IntLimit;
            internalFreqOk_q <= INT_CTRL_RESET[INT_OK_BIT];
            xtalSettle_q <= '0;
            crystalSettledFlag_q <= EXT_CTRL_RESET[EXT_FLAG_BIT];
        end
        else
        begin
            intSettle_q <= intSettle_d;
            internalFreqOk_q <= internalFreqOk_d;
            xtalSettle_q <= xtalSettle_d;
            crystalSettledFlag_q <= crystalSettledFlag_d;
        end
    end

    // Dividers for the internal prescaler and the external halving stage
    always_comb
    begin
        divCnt_d = intRise ? divCnt_q + 3'h1 : divCnt_q;
        extHalf_d = extRise ? !extHalf_q : extHalf_q;
        unique case (internalPrescaleSel_q) // RULE_02
            PRESC_DIV8: intSrcLevel = divCnt_q[2];
            PRESC_DIV4: intSrcLevel = divCnt_q[1];
            PRESC_DIV2: intSrcLevel = divCnt_q[0];
            PRESC_DIV1: intSrcLevel = intLevel;
        endcase
        intSrcLevel = intSrcLevel && internalOscOn_q; // RULE_03
        // Off for 00x, halved for 011, 10x and 111
        if (externalModeSel_q[2:1] == 2'h0) // RULE_13
        begin
            extSrcLevel = 1'b0;
        end
        else if (externalModeSel_q[0] || externalModeSel_q[2:1] == 2'h2)
        begin
            extSrcLevel = extHalf_q;
        end
        else
        begin
            extSrcLevel = extLevel;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            divCnt_q <= 3'h0;
            extHalf_q <= 1'b0;
        end
        else
        begin
            divCnt_q <= divCnt_d;
            extHalf_q <= extHalf_d;
        end
    end

    // Glitch-free source switch: drain old source low, wait new low
    switch_state_type swState_q, swState_d;
    source_type activeSrc_q, activeSrc_d;
    logic sysClk_q, sysClk_d;
    logic extTimerClk_q;
    logic activeLevel, pickLevel;

    always_comb
    begin
        activeLevel = (activeSrc_q == SRC_EXT) ? extSrcLevel : intSrcLevel;
        pickLevel = clockSourcePick_q ? extSrcLevel : intSrcLevel;
        swState_d = swState_q;
        activeSrc_d = activeSrc_q;
        sysClk_d = activeLevel;
        unique case (swState_q)
            SW_RUN:
            begin
                if (clockSourcePick_q != activeSrc_q) // RULE_07
                begin
                    swState_d = SW_DRAIN;
                end
            end
            SW_DRAIN:
            begin
                if (!activeLevel) // RULE_16
                begin
                    sysClk_d = 1'b0;
                    swState_d = SW_ARM;
                end
            end
            SW_ARM:
            begin
                sysClk_d = 1'b0;
                if (!pickLevel) // RULE_16
                begin
                    activeSrc_d = source_type'(clockSourcePick_q);
                    swState_d = SW_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            swState_q <= SW_RUN;
            activeSrc_q <= SRC_INT; // RULE_01
            sysClk_q <= 1'b0;
            extTimerClk_q <= 1'b0;
        end
        else
        begin
            swState_q <= swState_d;
            activeSrc_q <= activeSrc_d;
            sysClk_q <= sysClk_d;
            extTimerClk_q <= extSrcLevel; // RULE_09
        end
    end

    // Read mux, registered on the read strobe
    always_comb
    begin
        rdata_d = rdata_q;
        if (sfrRead)
        begin
            unique case (sfrAddr)
                ADDR_INT_CTRL: rdata_d = {internalOscOn_q, internalFreqOk_q, 4'h0,
                                          internalPrescaleSel_q};
                ADDR_INT_CAL: rdata_d = calibration_q;
                ADDR_EXT_CTRL: rdata_d = {crystalSettledFlag_q, externalModeSel_q, 1'b0,
                                          externalDriveRange_q}; // RULE_15
                ADDR_CLK_SEL: rdata_d = {7'h00, clockSourcePick_q}; // RULE_08
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs, each from a flip-flop
    assign sfrRdata = rdata_q;
    assign intOscEnable = internalOscOn_q;
    assign calTrim = calibration_q;
    assign extModeOut = externalModeSel_q;
    assign extDriveOut = externalDriveRange_q; // RULE_14
    assign extTimerClk = extTimerClk_q;
    assign sysClk = sysClk_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_reset_internal; // RULE_01
        $past(rst) |-> activeSrc_q == SRC_INT && !clockSourcePick_q && internalOscOn_q;
    endproperty
    a_reset_internal: assert property (p_reset_internal) else $error("not on internal after reset");

    property p_div1_follows; // RULE_02
        (swState_q == SW_RUN && activeSrc_q == SRC_INT && internalOscOn_q
            && internalPrescaleSel_q == PRESC_DIV1) |=> sysClk_q == $past(intLevel);
    endproperty
    a_div1_follows: assert property (p_div1_follows) else $error("divide by one wrong");

    property p_enable_write; // RULE_03
        wrIntCtrl |=> intOscEnable == $past(sfrWdata[INT_ON_BIT]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable bit not stored");

    property p_ok_needs_on; // RULE_04
        !internalOscOn_q |-> !internalFreqOk_q;
    endproperty
    a_ok_needs_on: assert property (p_ok_needs_on) else $error("ready while disabled");

    property p_cal_write; // RULE_05
        wrCal |=> calTrim == $past(sfrWdata);
    endproperty
    a_cal_write: assert property (p_cal_write) else $error("calibration not stored");

    property p_flag_crystal; // RULE_11
        !crystalMode |=> !crystalSettledFlag_q;
    endproperty
    a_flag_crystal: assert property (p_flag_crystal) else $error("flag outside crystal");

    property p_ext_off; // RULE_13
        externalModeSel_q[2:1] == 2'h0 |=> !extTimerClk;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("clock from disabled external");

    property p_rsvd_zero; // RULE_15
        sfrRead && sfrAddr == ADDR_EXT_CTRL |=> !sfrRdata[EXT_RSVD_BIT];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit nonzero");

    sequence s_swapped;
        activeSrc_q != $past(activeSrc_q);
    endsequence
    property p_clean_swap; // RULE_16
        s_swapped |-> !sysClk_q && !$past(sysClk_q);
    endproperty
    a_clean_swap: assert property (p_clean_swap) else $error("switch not at low level");

endmodule : system_clock_source_control

// file: bench/osc_partner.sv
module osc_partner
#(
    parameter int IntHalf = 5,
    parameter int ExtHalf = 7
)
(
    input wire logic clock,
    input wire logic intOn,
    input wire logic [2:0] extMode,
    output logic intOscRaw,
    output logic oscPinA
);
    timeunit 1ns;
    timeprecision 1ps;

    int intCnt = 0;
    int extCnt = 0;

    initial intOscRaw = 1'h0;
    initial oscPinA = 1'h0;

    // Internal oscillator, parked low while disabled
    always @(posedge clock)
    begin
        intCnt <= (intOn && intCnt < IntHalf - 1) ? intCnt + 1 : 0;
        if (!intOn)
            intOscRaw <= 1'h0;
        else if (intCnt == IntHalf - 1)
            intOscRaw <= !intOscRaw;
    end

    // External source, standing low while the circuit is off
    always @(posedge clock)
    begin
        extCnt <= (extMode[2:1] != 2'h0 && extCnt < ExtHalf - 1) ? extCnt + 1 : 0;
        if (extMode[2:1] == 2'h0)
            oscPinA <= 1'h0;
        else if (extCnt == ExtHalf - 1)
            oscPinA <= !oscPinA;
    end
endmodule : osc_partner

// file: bench/system_clock_source_control_tb_top.sv
module system_clock_source_control_tb_top import clock_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] CalInit = 8'h3C;
    localparam int IntPer = 10;
    localparam int ExtTab[8] = '{0, 0, 14, 28, 28, 28, 14, 28};

    logic clock = 1'h0;
    logic rst = 1'h1;
    logic sfrWrite = 1'h0;
    logic sfrRead = 1'h0;
    logic [7:0] sfrAddr = 8'h00;
    logic [7:0] sfrWdata = 8'h00;
    logic [7:0] sfrRdata;
    logic intOscRaw;
    logic oscPinA;
    logic intOscEnable;
    logic [7:0] calTrim;
    logic [2:0] extModeOut;
    logic [2:0] extDriveOut;
    logic extTimerClk;
    logic sysClk;
    int errorCnt = 0;
    int compares = 0;
    int cyc = 0;

    system_clock_source_control #(.CalReset(CalInit), .IntSettleEdges(4), .XtalSettleEdges(8))
    i_dut (.clock(clock), .rst(rst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .intOscRaw(intOscRaw), .oscPinA(oscPinA), .intOscEnable(intOscEnable),
        .calTrim(calTrim), .extModeOut(extModeOut), .extDriveOut(extDriveOut),
        .extTimerClk(extTimerClk), .sysClk(sysClk));

    osc_partner i_osc (.clock(clock), .intOn(intOscEnable), .extMode(extModeOut),
        .intOscRaw(intOscRaw), .oscPinA(oscPinA));

    // Clock and run limit
    always #2 clock = ~clock;
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            errorCnt++;
            endSim();
        end
    end

    task automatic endSim();
        $display("Checks %0d, errors %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : endSim

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWrite <= 1'h1;
        @(posedge clock);
        sfrWrite <= 1'h0;
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        sfrAddr <= a;
        sfrRead <= 1'h1;
        @(posedge clock);
        sfrRead <= 1'h0;
        @(negedge clock);
        check(sfrRdata, exp);
    endtask : rc

    // Cycles between two rising edges of sysClk or extTimerClk, 0 if stopped
    task automatic period(input logic ext, output int n);
        int k;
        int edges;
        int first;
        logic s;
        logic prev;
        n = 0;
        edges = 0;
        first = 0;
        repeat (200) @(negedge clock);
        prev = ext ? extTimerClk : sysClk;
        for (k = 0; k < 600 && edges < 2; k++)
        begin
            @(negedge clock);
            s = ext ? extTimerClk : sysClk;
            if (s === 1'h1 && prev === 1'h0)
            begin
                edges++;
                if (edges == 1)
                    first = k;
                else
                    n = k - first;
            end
            prev = s;
        end
    endtask : period

    // Shortest complete high or low run of sysClk over a window
    task automatic watch(output int minRun);
        int k;
        int run;
        bit seen;
        logic prev;
        minRun = 999;
        run = 0;
        seen = 0;
        prev = sysClk;
        for (k = 0; k < 300; k++)
        begin
            @(negedge clock);
            run++;
            if (sysClk !== prev)
            begin
                if (seen && run < minRun)
                    minRun = run;
                seen = 1;
                run = 0;
                prev = sysClk;
            end
        end
    endtask : watch

    task automatic tReset();
        int n;
        @(negedge clock);
        check({7'h00, intOscEnable}, 8'h01);
        check(calTrim, CalInit);
        rc(ADDR_INT_CTRL, INT_CTRL_RESET);
        rc(ADDR_INT_CAL, CalInit);
        rc(ADDR_EXT_CTRL, EXT_CTRL_RESET);
        rc(ADDR_CLK_SEL, CLK_SEL_RESET);
        period(1'h0, n);
        check(n[7:0], 8'(IntPer * 8));
    endtask : tReset

    task automatic tRegs();
        wr(ADDR_CLK_SEL, 8'hFE);
        rc(ADDR_CLK_SEL, 8'h00);
        wr(ADDR_EXT_CTRL, 8'h0F);
        rc(ADDR_EXT_CTRL, 8'h07);
        wr(8'h8D, 8'hFF);
        rc(8'h8D, 8'h00);
        wr(ADDR_INT_CAL, 8'h70);
        rc(ADDR_INT_CAL, 8'h70);
        check(calTrim, 8'h70);
    endtask : tRegs

    task automatic tPrescale();
        int n;
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_INT_CTRL, 8'h80 | 8'(c));
            period(1'h0, n);
            check(n[7:0], 8'(IntPer << (3 - c)));
        end
    endtask : tPrescale

    task automatic tEnable();
        int n;
        wr(ADDR_INT_CTRL, 8'h03);
        @(negedge clock);
        check({7'h00, intOscEnable}, 8'h00);
        repeat (30) @(negedge clock);
        rc(ADDR_INT_CTRL, 8'h03);
        period(1'h0, n);
        check(n[7:0], 8'h00);
        wr(ADDR_INT_CTRL, 8'h83);
        repeat (150) @(negedge clock);
        rc(ADDR_INT_CTRL, 8'hC3);
        period(1'h0, n);
        check(n[7:0], 8'(IntPer));
    endtask : tEnable

    task automatic tModes();
        int n;
        logic [2:0] m;
        for (int i = 0; i < 8; i++)
        begin
            m = 3'(i);
            wr(ADDR_EXT_CTRL, {1'h0, m, 1'h1, m});
            rc(ADDR_EXT_CTRL, {1'h0, m, 1'h0, m});
            check({5'h00, extModeOut}, {5'h00, m});
            check({5'h00, extDriveOut}, {5'h00, m});
            repeat (300) @(negedge clock);
            rc(ADDR_EXT_CTRL, {m[2:1] == 2'h3, m, 1'h0, m});
            period(1'h1, n);
            check(n[7:0], 8'(ExtTab[i]));
        end
    endtask : tModes

    task automatic tSwitch();
        int n;
        wr(ADDR_EXT_CTRL, 8'h67);
        repeat (300) @(negedge clock);
        rc(ADDR_EXT_CTRL, 8'hE7);
        wr(ADDR_CLK_SEL, 8'h01);
        watch(n);
        check({7'h00, n >= 5}, 8'h01);
        rc(ADDR_CLK_SEL, 8'h01);
        period(1'h0, n);
        check(n[7:0], 8'(ExtTab[6]));
        wr(ADDR_CLK_SEL, 8'h00);
        watch(n);
        check({7'h00, n >= 5}, 8'h01);
        period(1'h0, n);
        check(n[7:0], 8'(IntPer));
        wr(ADDR_CLK_SEL, 8'h01);
        repeat (100) @(posedge clock);
        rst <= 1'h1;
        repeat (20) @(posedge clock);
        rst <= 1'h0;
        rc(ADDR_CLK_SEL, 8'h00);
        period(1'h0, n);
        check(n[7:0], 8'(IntPer * 8));
    endtask : tSwitch

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clock);
        rst <= 1'h0;
        tReset();
        tRegs();
        tPrescale();
        tEnable();
        tModes();
        tSwitch();
        endSim();
    end
endmodule : system_clock_source_control_tb_top
